//--- core/oscdiv_pkg.sv
// Purpose: Constants for the oscillator switch and clock divisor block
// Assumes: APB with 32-bit data, one aligned word per register
// Notes:   Offsets below are local choices
package oscdiv_pkg;

    // ****************************************
    // Register map
    // ****************************************
    localparam logic [11:0] OSCDIV_OFS_OSC_CTRL  = 12'h000;
    localparam logic [11:0] OSCDIV_OFS_CLK_DIV   = 12'h004;
    localparam logic [11:0] OSCDIV_OFS_NEW_SRC   = 12'h008;
    localparam logic [11:0] OSCDIV_OFS_UNLOCK    = 12'h00C;

    // Oscillator control fields
    localparam int OSCDIV_BIT_SWITCH_REQ  = 0;
    localparam int OSCDIV_BIT_SEC_OSC_EN  = 1;
    localparam logic [15:0] OSCDIV_OSC_CTRL_MASK = 16'h0003;

    // Clock divisor fields
    localparam int OSCDIV_BIT_ROI        = 15;
    localparam int OSCDIV_POS_RATIO      = 12;
    localparam int OSCDIV_BIT_RATIO_EN   = 11;
    localparam int OSCDIV_POS_RC_POST    = 8;
    localparam int OSCDIV_POS_PLL_POST   = 6;
    localparam int OSCDIV_POS_PLL_PRE    = 0;
    localparam logic [15:0] OSCDIV_CLK_DIV_MASK  = 16'hFFDF;
    localparam logic [15:0] OSCDIV_CLK_DIV_RESET = 16'h3040;

    // Unlock keys written in order to the unlock register
    localparam logic [15:0] OSCDIV_KEY_FIRST  = 16'h0046;
    localparam logic [15:0] OSCDIV_KEY_SECOND = 16'h0057;

    // Switch settle time in cycles
    localparam logic [7:0] OSCDIV_SWITCH_CYCLES = 8'h10;
    localparam logic [2:0] OSCDIV_SRC_RESET     = 3'h0;

    // Unlock state machine, Gray coded
    typedef enum logic [1:0] {
        OSCDIV_LOCKED = 2'b00,
        OSCDIV_KEY1   = 2'b01,
        OSCDIV_OPEN   = 2'b11
    } oscdiv_unlock_t;

endpackage : oscdiv_pkg

//--- core/oscdiv_div_if.sv
// Purpose: Carries divider settings from register file to clock divider
// Assumes: One clock domain
// Notes:   Plain bundle, no timing of its own
`timescale 1ns/1ps
interface oscdiv_div_if;
    logic [2:0] proc_clock_ratio;
    logic       proc_ratio_enable;
    logic [2:0] internal_rc_postscaler;
    logic       proc_tick;
    logic       rc_tick;
    modport ctrl (output proc_clock_ratio, output proc_ratio_enable,
                  output internal_rc_postscaler, input proc_tick, input rc_tick);
    modport div  (input proc_clock_ratio, input proc_ratio_enable,
                  input internal_rc_postscaler, output proc_tick, output rc_tick);
endinterface : oscdiv_div_if

//--- core/oscdiv_divider.sv
// Purpose: Power-of-two enable dividers for processor and RC clocks
// Assumes: Enables are one-cycle pulses on ref_clk
// Notes:   Ratio 0 gives a pulse every cycle
`timescale 1ns/1ps
module oscdiv_divider
    import oscdiv_pkg::*;
(
    input  wire logic ref_clk,
    input  wire logic resetn,
    oscdiv_div_if.div d
);

    logic [6:0] proc_cnt;
    logic [6:0] next_proc_cnt;
    logic [6:0] rc_cnt;
    logic [6:0] next_rc_cnt;
    logic [6:0] proc_lim;
    logic [6:0] rc_lim;

    // ****************************************
    // Divider counters
    // ****************************************
    // Limit is 2^n - 1; disabled ratio means 1:1
    always_comb begin
        proc_lim = d.proc_ratio_enable ? 7'((8'h01 << d.proc_clock_ratio) - 8'h01)
                                       : 7'h00;
        rc_lim   = 7'((8'h01 << d.internal_rc_postscaler) - 8'h01);
        next_proc_cnt = (proc_cnt >= proc_lim) ? 7'h00 : proc_cnt + 7'h01;
        next_rc_cnt   = (rc_cnt >= rc_lim) ? 7'h00 : rc_cnt + 7'h01;
    end

    always_ff @(posedge ref_clk or negedge resetn) begin
        if (!resetn) begin
            proc_cnt <= 7'h00;
            rc_cnt   <= 7'h00;
        end else begin
            proc_cnt <= next_proc_cnt;
            rc_cnt   <= next_rc_cnt;
        end
    end

    // Tick on wrap; a shrunk limit wraps at once rather than stalling
    assign d.proc_tick = (proc_cnt >= proc_lim);
    assign d.rc_tick   = (rc_cnt >= rc_lim);

endmodule : oscdiv_divider

//--- core/oscdiv_top.sv
// Purpose: Oscillator switch control and clock divisor registers on APB
// Assumes: Interrupt input is synchronous to ref_clk
// Notes:   Clock sources are modelled as enables and select codes
//
// Local design decisions: the APB slave port and the register offsets.
`timescale 1ns/1ps
module oscdiv_top
    import oscdiv_pkg::*;
(
    input  wire logic        ref_clk,
    input  wire logic        resetn,
    input  wire logic        psel,
    input  wire logic        penable,
    input  wire logic        pwrite,
    input  wire logic [11:0] paddr,
    input  wire logic [31:0] pwdata,
    output logic      [31:0] prdata,
    output logic             pready,
    output logic             pslverr,
    input  wire logic        irq_event,
    output logic             secondary_osc_run,
    output logic      [2:0]  active_source,
    output logic             proc_clk_en,
    output logic             rc_clk_en,
    output logic      [3:0]  pll_output_ratio,
    output logic      [5:0]  pll_input_ratio
);

    oscdiv_div_if d ();

    logic [15:0]    osc_ctrl;
    logic [15:0]    next_osc_ctrl;
    logic [15:0]    clk_div;
    logic [15:0]    next_clk_div;
    logic [2:0]     new_source_select;
    logic [2:0]     next_new_source_select;
    logic [2:0]     next_active_source;
    logic [7:0]     sw_cnt;
    logic [7:0]     next_sw_cnt;
    oscdiv_unlock_t unlock;
    oscdiv_unlock_t next_unlock;
    logic [31:0]    next_prdata;
    logic           next_pslverr;
    logic           wr;
    logic           rd;
    logic           hit;
    logic [15:0]    wdat;

    // ****************************************
    // APB decode
    // ****************************************
    // Zero wait states: every access completes in its first access cycle
    assign pready = 1'b1;
    assign wr     = psel & penable & pwrite;
    assign rd     = psel & ~penable & ~pwrite;
    assign wdat   = pwdata[15:0];
    assign hit    = (paddr == OSCDIV_OFS_OSC_CTRL) | (paddr == OSCDIV_OFS_CLK_DIV) |
                    (paddr == OSCDIV_OFS_NEW_SRC)  | (paddr == OSCDIV_OFS_UNLOCK);

    // ****************************************
    // Unlock sequence and oscillator control
    // ****************************************
    always_comb begin
        next_unlock            = unlock;
        next_osc_ctrl          = osc_ctrl;
        next_new_source_select = new_source_select;
        next_active_source     = active_source;
        next_sw_cnt            = sw_cnt;
        // Any other write relocks, so a stray write cannot leave it open
        if (wr) begin
            next_unlock = OSCDIV_LOCKED;
            if (paddr == OSCDIV_OFS_UNLOCK && wdat == OSCDIV_KEY_FIRST) begin
                next_unlock = OSCDIV_KEY1;
            end else if (paddr == OSCDIV_OFS_UNLOCK && unlock == OSCDIV_KEY1 &&
                         wdat == OSCDIV_KEY_SECOND) begin
                next_unlock = OSCDIV_OPEN;
            end
        end
        // Write taken only while open; a switch in flight holds its request
        if (wr && paddr == OSCDIV_OFS_OSC_CTRL && unlock == OSCDIV_OPEN) begin
            next_osc_ctrl[OSCDIV_BIT_SEC_OSC_EN] = wdat[OSCDIV_BIT_SEC_OSC_EN];
            if (wdat[OSCDIV_BIT_SWITCH_REQ] && !osc_ctrl[OSCDIV_BIT_SWITCH_REQ]) begin
                next_osc_ctrl[OSCDIV_BIT_SWITCH_REQ] = 1'b1;
                next_sw_cnt = OSCDIV_SWITCH_CYCLES;
            end
        end
        if (wr && paddr == OSCDIV_OFS_NEW_SRC && unlock == OSCDIV_OPEN &&
            !osc_ctrl[OSCDIV_BIT_SWITCH_REQ]) begin
            next_new_source_select = wdat[2:0];
        end
        // Count settle time, then move source and drop the request
        if (osc_ctrl[OSCDIV_BIT_SWITCH_REQ]) begin
            if (sw_cnt == 8'h00) begin
                next_active_source = new_source_select;
                next_osc_ctrl[OSCDIV_BIT_SWITCH_REQ] = 1'b0;
            end else begin
                next_sw_cnt = sw_cnt - 8'h01;
            end
        end
        next_osc_ctrl = next_osc_ctrl & OSCDIV_OSC_CTRL_MASK;
    end

    always_ff @(posedge ref_clk or negedge resetn) begin
        if (!resetn) begin
            unlock            <= OSCDIV_LOCKED;
            osc_ctrl          <= 16'h0000;
            new_source_select <= OSCDIV_SRC_RESET;
            active_source     <= OSCDIV_SRC_RESET;
            sw_cnt            <= 8'h00;
        end else begin
            unlock            <= next_unlock;
            osc_ctrl          <= next_osc_ctrl;
            new_source_select <= next_new_source_select;
            active_source     <= next_active_source;
            sw_cnt            <= next_sw_cnt;
        end
    end

    // ****************************************
    // Clock divisor register
    // ****************************************
    always_comb begin
        next_clk_div = clk_div;
        if (wr && paddr == OSCDIV_OFS_CLK_DIV) begin
            next_clk_div = wdat & OSCDIV_CLK_DIV_MASK;
        end
        // Interrupt wins over a same-cycle write of the enable bit
        if (irq_event && next_clk_div[OSCDIV_BIT_ROI]) begin
            next_clk_div[OSCDIV_BIT_RATIO_EN] = 1'b0;
        end
    end

    always_ff @(posedge ref_clk or negedge resetn) begin
        if (!resetn) begin
            clk_div <= OSCDIV_CLK_DIV_RESET;
        end else begin
            clk_div <= next_clk_div;
        end
    end

    // ****************************************
    // Read data
    // ****************************************
    always_comb begin
        next_prdata  = 32'h0000_0000;
        next_pslverr = 1'b0;
        unique case (paddr)
            OSCDIV_OFS_OSC_CTRL: next_prdata = {16'h0000, osc_ctrl};
            OSCDIV_OFS_CLK_DIV:  next_prdata = {16'h0000, clk_div};
            OSCDIV_OFS_NEW_SRC:  next_prdata = {29'h0000_0000, new_source_select};
            OSCDIV_OFS_UNLOCK:   next_prdata = {30'h0000_0000, unlock};
            default:             next_prdata = 32'h0000_0000;
        endcase
        next_pslverr = ~hit;
    end

    // Registered in setup so data is steady throughout the access phase
    always_ff @(posedge ref_clk or negedge resetn) begin
        if (!resetn) begin
            prdata  <= 32'h0000_0000;
            pslverr <= 1'b0;
        end else if (rd) begin
            prdata  <= next_prdata;
            pslverr <= next_pslverr;
        end else if (psel & ~penable) begin
            pslverr <= next_pslverr;
        end
    end

    // ****************************************
    // Clock outputs
    // ****************************************
    assign secondary_osc_run = osc_ctrl[OSCDIV_BIT_SEC_OSC_EN];
    // PLL dividers; reserved code 10 passes as 8 since software avoids it
    assign pll_output_ratio  = clk_div[OSCDIV_POS_PLL_POST +: 2] == 2'b00 ? 4'h2 :
                               clk_div[OSCDIV_POS_PLL_POST +: 2] == 2'b01 ? 4'h4 :
                               4'h8;
    assign pll_input_ratio   = {1'b0, clk_div[OSCDIV_POS_PLL_PRE +: 5]} + 6'h02;

    assign d.proc_clock_ratio       = clk_div[OSCDIV_POS_RATIO +: 3];
    assign d.proc_ratio_enable      = clk_div[OSCDIV_BIT_RATIO_EN];
    assign d.internal_rc_postscaler = clk_div[OSCDIV_POS_RC_POST +: 3];
    assign proc_clk_en = d.proc_tick;
    assign rc_clk_en   = d.rc_tick;

    oscdiv_divider u_div (
        .ref_clk (ref_clk),
        .resetn  (resetn),
        .d       (d)
    );

endmodule : oscdiv_top

//--- testbench/oscdiv_asserts.sv
// Purpose: Port-level checks for the oscillator switch and divisor block
// Assumes: Single ref_clk domain, resetn active low
// Notes:   Read data is latched at the setup edge, so checks look one cycle on
`timescale 1ns/1ps
module oscdiv_asserts
    import oscdiv_pkg::*;
(
    input wire logic        ref_clk,
    input wire logic        resetn,
    input wire logic        psel,
    input wire logic        penable,
    input wire logic        pwrite,
    input wire logic [11:0] paddr,
    input wire logic [31:0] prdata,
    input wire logic        pready,
    input wire logic        pslverr,
    input wire logic        secondary_osc_run,
    input wire logic [3:0]  pll_output_ratio,
    input wire logic [5:0]  pll_input_ratio
);
    // ****************************************
    // Properties
    // ****************************************
    default clocking cb @(posedge ref_clk); endclocking
    default disable iff (!resetn);
    // Read setup cycle, answer shows one cycle later
    wire rd_setup = psel && !penable && !pwrite;

    chk_ready_high: assert property (pready) else $error("pready low");
    // Writes leave read data alone, so only reads must show zero
    chk_unmapped_err: assert property (psel && !penable && paddr == 12'h010
        |=> pslverr && ($past(pwrite) || prdata == 32'h0))
        else $error("unmapped access not refused");
    chk_osc_zero_bits: assert property (rd_setup && paddr == OSCDIV_OFS_OSC_CTRL
        |=> prdata[31:2] == 30'h0) else $error("osc control spare bits set");
    chk_div_zero_bits: assert property (rd_setup && paddr == OSCDIV_OFS_CLK_DIV
        |=> prdata[31:16] == 16'h0 && !prdata[5]) else $error("divisor spare bits set");
    chk_post_legal: assert property (pll_output_ratio inside {4'h2, 4'h4, 4'h8})
        else $error("pll output ratio illegal");
    chk_pre_range: assert property (pll_input_ratio inside {[6'h02:6'h21]})
        else $error("pll input ratio out of range");
    chk_sec_osc_cause: assert property ($changed(secondary_osc_run)
        |-> $past(psel && penable && pwrite && paddr == OSCDIV_OFS_OSC_CTRL))
        else $error("secondary osc changed without write");
endmodule : oscdiv_asserts

//--- testbench/osc_switch_and_clock_divisor_tb.sv
// Purpose: Self-checking bench for the oscillator switch and divisor block
// Assumes: APB slave signals completion with pready
// Notes:   Divider periods are measured between enable pulses
`timescale 1ns/1ps
module osc_switch_and_clock_divisor_tb
    import oscdiv_pkg::*;
;
    typedef struct {logic [15:0] w; logic [15:0] rd; logic [3:0] po; logic [5:0] pi;} oscdiv_row_t;
    logic        ref_clk, resetn, psel, penable, pwrite, pready, pslverr, irq_event;
    logic        secondary_osc_run, proc_clk_en, rc_clk_en;
    logic [11:0] paddr;
    logic [31:0] pwdata, prdata, q;
    logic [2:0]  active_source;
    logic [3:0]  pll_output_ratio;
    logic [5:0]  pll_input_ratio;
    int          fail_count, compares, n;
    // Write value, read-back, output ratio, input ratio
    oscdiv_row_t rows[5] = '{'{16'h0000, 16'h0000, 4'h2, 6'h02}, '{16'h0041, 16'h0041, 4'h4, 6'h03},
        '{16'h00FF, 16'h00DF, 4'h8, 6'h21}, '{16'hFFFF, 16'hFFDF, 4'h8, 6'h21},
        '{16'h3040, 16'h3040, 4'h4, 6'h02}};

    oscdiv_top u_oscdiv_top (.ref_clk(ref_clk), .resetn(resetn), .psel(psel), .penable(penable),
        .pwrite(pwrite), .paddr(paddr), .pwdata(pwdata), .prdata(prdata), .pready(pready),
        .pslverr(pslverr), .irq_event(irq_event), .secondary_osc_run(secondary_osc_run),
        .active_source(active_source), .proc_clk_en(proc_clk_en), .rc_clk_en(rc_clk_en),
        .pll_output_ratio(pll_output_ratio), .pll_input_ratio(pll_input_ratio));

    // ****************************************
    // Tasks
    // ****************************************
    task chk(input logic [31:0] seen, input logic [31:0] exp, input string msg);
        compares++;
        if (seen !== exp) begin
            fail_count++;
            $display("wrong value at %0t: %s seen %h expected %h", $time, msg, seen, exp);
        end
    endtask : chk

    // One APB transfer; ends at a falling edge so outputs have settled
    task apb(input logic wr, input logic [11:0] a, input logic [15:0] d);
        @(posedge ref_clk);
        psel <= 1'b1;
        penable <= 1'b0;
        pwrite <= wr;
        paddr <= a;
        pwdata <= {16'h0000, d};
        @(posedge ref_clk);
        penable <= 1'b1;
        // No cycle limit here: only the watchdog ends a stalled wait
        do begin
            @(posedge ref_clk);
        end while (pready !== 1'b1);
        q = prdata;
        psel <= 1'b0;
        penable <= 1'b0;
        @(negedge ref_clk);
    endtask : apb

    task unlock;
        apb(1'b1, OSCDIV_OFS_UNLOCK, OSCDIV_KEY_FIRST);
        apb(1'b1, OSCDIV_OFS_UNLOCK, OSCDIV_KEY_SECOND);
    endtask : unlock

    // Source change: unlock before each of the two writes, then poll for completion
    task switch_src(input logic [2:0] s);
        int t;
        unlock();
        apb(1'b1, OSCDIV_OFS_NEW_SRC, {13'h0000, s});
        unlock();
        apb(1'b1, OSCDIV_OFS_OSC_CTRL, 16'h0001);
        t = 0;
        do begin
            apb(1'b0, OSCDIV_OFS_OSC_CTRL, 16'h0000);
            t++;
        end while (q[0] !== 1'b0 && t < 20);
        chk(q, 32'h0, "switch complete");
        chk(32'(active_source), 32'(s), "new source");
    endtask : switch_src

    // Third pulse interval, so a phase jump after a write is skipped
    task per(input logic rc, output int p);
        for (int i = 0; i < 3; i++) begin
            p = 0;
            do begin
                @(negedge ref_clk);
                p++;
            end while ((rc ? rc_clk_en : proc_clk_en) !== 1'b1 && p < 300);
        end
    endtask : per

    task irq_pulse;
        @(posedge ref_clk);
        irq_event <= 1'b1;
        @(posedge ref_clk);
        irq_event <= 1'b0;
    endtask : irq_pulse

    task give_verdict;
        $display("comparisons %0d mismatches %0d", compares, fail_count);
        if (fail_count == 0 && compares > 0) begin
            $display("Test passed");
        end else begin
            $display("Test failed");
        end
        $finish;
    endtask : give_verdict

    // ****************************************
    // Clock, watchdog and main sequence
    // ****************************************
    initial begin
        ref_clk = 1'b0;
        forever #4 ref_clk = ~ref_clk;
    end

    // Longest test is the divider sweep, well under this span
    initial begin
        repeat (30000) @(posedge ref_clk);
        fail_count++;
        give_verdict;
    end

    initial begin
        {resetn, psel, penable, pwrite, irq_event} = 5'h00;
        paddr = 12'h000;
        pwdata = 32'h0;
        fail_count = 0;
        compares = 0;
        repeat (16) @(posedge ref_clk);
        resetn <= 1'b1;
        apb(1'b0, OSCDIV_OFS_CLK_DIV, 16'h0000);
        chk(q, {16'h0000, OSCDIV_CLK_DIV_RESET}, "divisor reset");
        apb(1'b0, OSCDIV_OFS_OSC_CTRL, 16'h0000);
        chk(q, 32'h0, "osc control reset");
        $display("reset test done");
        foreach (rows[i]) begin
            apb(1'b1, OSCDIV_OFS_CLK_DIV, rows[i].w);
            apb(1'b0, OSCDIV_OFS_CLK_DIV, 16'h0000);
            chk(q, {16'h0000, rows[i].rd}, "divisor readback");
            chk(32'(pll_output_ratio), 32'(rows[i].po), "pll output ratio");
            chk(32'(pll_input_ratio), 32'(rows[i].pi), "pll input ratio");
        end
        $display("table test done");
        for (int c = 0; c < 8; c++) begin
            apb(1'b1, OSCDIV_OFS_CLK_DIV, 16'(c << 8));
            per(1'b1, n);
            chk(32'(n), 32'(1 << c), "rc period");
            per(1'b0, n);
            chk(32'(n), 32'h1, "ratio disabled period");
            apb(1'b1, OSCDIV_OFS_CLK_DIV, 16'((c << 12) | 16'h0800));
            per(1'b0, n);
            chk(32'(n), 32'(1 << c), "proc period");
        end
        $display("divider test done");
        apb(1'b1, OSCDIV_OFS_OSC_CTRL, 16'h0002);
        chk(32'(secondary_osc_run), 32'h0, "locked write took effect");
        unlock();
        apb(1'b1, OSCDIV_OFS_OSC_CTRL, 16'hFFFE);
        chk(32'(secondary_osc_run), 32'h1, "secondary osc on");
        apb(1'b0, OSCDIV_OFS_OSC_CTRL, 16'h0000);
        chk(q, 32'h2, "osc control spare bits");
        apb(1'b1, OSCDIV_OFS_OSC_CTRL, 16'h0000);
        chk(32'(secondary_osc_run), 32'h1, "relocked write took effect");
        unlock();
        apb(1'b1, OSCDIV_OFS_OSC_CTRL, 16'h0000);
        chk(32'(secondary_osc_run), 32'h0, "secondary osc off");
        $display("unlock test done");
        unlock();
        apb(1'b1, OSCDIV_OFS_NEW_SRC, 16'h0005);
        unlock();
        apb(1'b1, OSCDIV_OFS_OSC_CTRL, 16'h0001);
        apb(1'b0, OSCDIV_OFS_OSC_CTRL, 16'h0000);
        chk(q, 32'h1, "switch pending");
        n = 0;
        do begin
            apb(1'b0, OSCDIV_OFS_OSC_CTRL, 16'h0000);
            n++;
        end while (q[0] !== 1'b0 && n < 20);
        chk(q, 32'h0, "switch complete");
        chk(32'(active_source), 32'h5, "new source");
        // PLL to PLL only by way of plain fast internal RC
        switch_src(3'h1);
        switch_src(3'h0);
        switch_src(3'h3);
        $display("switch test done");
        apb(1'b1, OSCDIV_OFS_CLK_DIV, 16'h8800);
        irq_pulse();
        apb(1'b0, OSCDIV_OFS_CLK_DIV, 16'h0000);
        chk(q, 32'h8000, "recover on interrupt");
        apb(1'b1, OSCDIV_OFS_CLK_DIV, 16'h0800);
        irq_pulse();
        apb(1'b0, OSCDIV_OFS_CLK_DIV, 16'h0000);
        chk(q, 32'h0800, "interrupt without recover");
        apb(1'b0, 12'h010, 16'h0000);
        chk({q[30:0], pslverr}, 32'h1, "unmapped read");
        $display("interrupt and error test done");
        // Reset in mid-run: registers, source and lock return to reset values
        @(posedge ref_clk);
        resetn <= 1'b0;
        repeat (2) @(posedge ref_clk);
        resetn <= 1'b1;
        apb(1'b0, OSCDIV_OFS_CLK_DIV, 16'h0000);
        chk(q, {16'h0000, OSCDIV_CLK_DIV_RESET}, "divisor after reset");
        chk(32'(pll_output_ratio), 32'h4, "pll output ratio after reset");
        chk(32'(active_source), 32'(OSCDIV_SRC_RESET), "source after reset");
        apb(1'b1, OSCDIV_OFS_OSC_CTRL, 16'h0002);
        chk(32'(secondary_osc_run), 32'h0, "reset left control unlocked");
        $display("mid-run reset test done");
        give_verdict();
    end
endmodule : osc_switch_and_clock_divisor_tb

bind oscdiv_top oscdiv_asserts u_oscdiv_asserts (.ref_clk(ref_clk), .resetn(resetn),
    .psel(psel), .penable(penable), .pwrite(pwrite), .paddr(paddr), .prdata(prdata),
    .pready(pready), .pslverr(pslverr), .secondary_osc_run(secondary_osc_run),
    .pll_output_ratio(pll_output_ratio), .pll_input_ratio(pll_input_ratio));
